// File: bench/display_scan_and_ram_setup_regs_tb.sv
// Self-checking bench of the setup register bank
`timescale 1ns/10ps
`default_nettype none
module display_scan_and_ram_setup_regs_tb;
  logic CLK = 1'b0, SYS_RST = 1'b1, CMD_WR, MEM_ACCESS, HORIZONTAL_FLIP, VERTICAL_FLIP;
  logic X_AUTO_STEP, Y_AUTO_STEP, GRAY_DEPTH_VALID;
  logic [15:0] CMD_WORD;
  logic [7:0] PIX_COL, COLUMN_POINTER_START, ROW_POINTER_START, X_PTR, Y_PTR, PIX_COL_MAPPED;
  logic [6:0] SCAN_LINE_INDEX, LAST_SCAN_LINE;
  logic [3:0] DUMMY_LINES, GRAY_DEPTH_SELECT;
  logic [1:0] DUMMY_LINE_COUNT;
  localparam logic [15:0] LEGAL = 16'h0B3D;
  int error_cnt = 0;
  int checks = 0;
  always #20 CLK = ~CLK;
  dsr_regs dut (
    .CLK                  (CLK),
    .SYS_RST              (SYS_RST),
    .CMD_WR               (CMD_WR),
    .CMD_WORD             (CMD_WORD),
    .MEM_ACCESS           (MEM_ACCESS),
    .PIX_COL              (PIX_COL),
    .HORIZONTAL_FLIP      (HORIZONTAL_FLIP),
    .VERTICAL_FLIP        (VERTICAL_FLIP),
    .DUMMY_LINE_COUNT     (DUMMY_LINE_COUNT),
    .DUMMY_LINES          (DUMMY_LINES),
    .SCAN_LINE_INDEX      (SCAN_LINE_INDEX),
    .LAST_SCAN_LINE       (LAST_SCAN_LINE),
    .COLUMN_POINTER_START (COLUMN_POINTER_START),
    .ROW_POINTER_START    (ROW_POINTER_START),
    .X_AUTO_STEP          (X_AUTO_STEP),
    .Y_AUTO_STEP          (Y_AUTO_STEP),
    .GRAY_DEPTH_SELECT    (GRAY_DEPTH_SELECT),
    .GRAY_DEPTH_VALID     (GRAY_DEPTH_VALID),
    .X_PTR                (X_PTR),
    .Y_PTR                (Y_PTR),
    .PIX_COL_MAPPED       (PIX_COL_MAPPED)
  );
  dsr_host u_host (
    .CLK        (CLK),
    .CMD_WR     (CMD_WR),
    .CMD_WORD   (CMD_WORD),
    .MEM_ACCESS (MEM_ACCESS),
    .PIX_COL    (PIX_COL)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000 error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge CLK);
    #1 SYS_RST = 1'b0;
    chk({HORIZONTAL_FLIP, VERTICAL_FLIP, DUMMY_LINES}, 6'h01);
    chk({X_AUTO_STEP, Y_AUTO_STEP, GRAY_DEPTH_SELECT, GRAY_DEPTH_VALID}, 7'h01);
    chk({LAST_SCAN_LINE, SCAN_LINE_INDEX}, {7'd72, 7'h47});
    chk({COLUMN_POINTER_START, ROW_POINTER_START}, 16'h0000);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      u_host.send(8'h11, {2'b11, i[1:0], 2'b11, i[1:0]});
      chk({DUMMY_LINES, VERTICAL_FLIP, HORIZONTAL_FLIP}, {4'h1 << i, i[1:0]});
    end
    u_host.access(8'h12);
    chk(PIX_COL_MAPPED, 8'hED);
    u_host.send(8'h12, 8'h00);
    chk(LAST_SCAN_LINE, 7'd1);
    $display("test direction done");
    u_host.send(8'h13, 8'hFF);
    chk({COLUMN_POINTER_START, X_PTR}, 16'hFFFF);
    u_host.send(8'h14, 8'h80);
    chk({ROW_POINTER_START, Y_PTR}, 16'h8080);
    u_host.send(8'h15, 8'hBF);
    chk({GRAY_DEPTH_SELECT, X_AUTO_STEP, Y_AUTO_STEP}, 6'h2F);
    u_host.access(8'h00);
    chk({X_PTR, Y_PTR}, 16'h0081);
    u_host.send(8'h15, 8'h00);
    u_host.access(8'h00);
    chk({X_PTR, Y_PTR}, 16'h0081);
    $display("test pointers done");
    for (int g = 0; g < 16; g++) begin
      u_host.send(8'h15, {g[3:0], 4'h0});
      chk({GRAY_DEPTH_SELECT, GRAY_DEPTH_VALID}, {g[3:0], LEGAL[g]});
    end
    $display("test gray done");
    SYS_RST = 1'b1;
    repeat (2) @(posedge CLK);
    #1 SYS_RST = 1'b0;
    chk({HORIZONTAL_FLIP, VERTICAL_FLIP, DUMMY_LINE_COUNT, GRAY_DEPTH_SELECT}, 8'h00);
    chk({LAST_SCAN_LINE, GRAY_DEPTH_VALID, DUMMY_LINES}, {7'd72, 1'h1, 4'h1});
    chk({X_PTR, Y_PTR}, 16'h0000);
    u_host.access(8'h12);
    chk(PIX_COL_MAPPED, 8'h12);
    $display("test reset done");
    print_verdict;
  end
endmodule
`default_nettype wire

// File: bench/dsr_host.sv
// Host model sending command words and memory accesses
`timescale 1ns/10ps
`default_nettype none
module dsr_host (
  input  wire logic   CLK,
  output logic        CMD_WR = 1'b0,
  output logic [15:0] CMD_WORD = 16'h0000,
  output logic        MEM_ACCESS = 1'b0,
  output logic [7:0]  PIX_COL = 8'h00
);
  // Scan codes stay at or below 47h
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    @(posedge CLK);
    #1 CMD_WR = 1'b1;
    CMD_WORD = {c, d};
    @(posedge CLK);
    #1 CMD_WR = 1'b0;
    CMD_WORD = ~CMD_WORD;
  endtask
  task automatic access(input logic [7:0] col);
    @(posedge CLK);
    #1 MEM_ACCESS = 1'b1;
    PIX_COL = col;
    @(posedge CLK);
    #1 MEM_ACCESS = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/dsr_props.sv
// Checker of the setup register bank
`timescale 1ns/10ps
`default_nettype none
module dsr_props (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        CMD_WR,
  input wire logic [15:0] CMD_WORD,
  input wire logic        MEM_ACCESS,
  input wire logic [7:0]  PIX_COL,
  input wire logic        HORIZONTAL_FLIP,
  input wire logic        VERTICAL_FLIP,
  input wire logic [1:0]  DUMMY_LINE_COUNT,
  input wire logic [3:0]  DUMMY_LINES,
  input wire logic [6:0]  SCAN_LINE_INDEX,
  input wire logic [6:0]  LAST_SCAN_LINE,
  input wire logic [7:0]  COLUMN_POINTER_START,
  input wire logic [7:0]  ROW_POINTER_START,
  input wire logic        X_AUTO_STEP,
  input wire logic        Y_AUTO_STEP,
  input wire logic [3:0]  GRAY_DEPTH_SELECT,
  input wire logic        GRAY_DEPTH_VALID,
  input wire logic [7:0]  X_PTR,
  input wire logic [7:0]  Y_PTR,
  input wire logic [7:0]  PIX_COL_MAPPED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_wr(c);
    CMD_WR && CMD_WORD[15:8] == c;
  endsequence
  a_dir_load: assert property (
    s_wr(8'h11) |=> {DUMMY_LINE_COUNT, VERTICAL_FLIP, HORIZONTAL_FLIP} ==
                    $past({CMD_WORD[5:4], CMD_WORD[1:0]}))
    else $error("direction load wrong");
  a_scan_load: assert property (
    s_wr(8'h12) |=> SCAN_LINE_INDEX == $past(CMD_WORD[6:0]))
    else $error("scan line load wrong");
  a_y_load: assert property (
    s_wr(8'h14) |=> Y_PTR == $past(CMD_WORD[7:0]) && ROW_POINTER_START == Y_PTR)
    else $error("y start wrong");
  a_y_step: assert property (
    MEM_ACCESS && Y_AUTO_STEP && !CMD_WR |=> Y_PTR == $past(Y_PTR) + 8'h01)
    else $error("y step wrong");
  a_mirror_col: assert property (
    MEM_ACCESS |=> PIX_COL_MAPPED == ($past(PIX_COL) ^ {8{HORIZONTAL_FLIP}}))
    else $error("column mirror wrong");
  a_dummy_decode: assert property (DUMMY_LINES == 4'h1 << DUMMY_LINE_COUNT)
    else $error("dummy decode wrong");
  a_last_line: assert property (LAST_SCAN_LINE == SCAN_LINE_INDEX + 7'h01)
    else $error("last line wrong");
  a_x_load: assert property (
    s_wr(8'h13) |=> X_PTR == $past(CMD_WORD[7:0]) && COLUMN_POINTER_START == X_PTR)
    else $error("x start wrong");
  a_x_step: assert property (
    MEM_ACCESS && X_AUTO_STEP && !CMD_WR |=> X_PTR == $past(X_PTR) + 8'h01)
    else $error("x step wrong");
  a_x_hold: assert property (!X_AUTO_STEP && !CMD_WR |=> $stable(X_PTR))
    else $error("x moved");
  a_gray_legal: assert property (
    GRAY_DEPTH_VALID == (GRAY_DEPTH_SELECT inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hB}))
    else $error("gray valid wrong");
endmodule
bind dsr_regs dsr_props u_props (
  .CLK                  (CLK),
  .SYS_RST              (SYS_RST),
  .CMD_WR               (CMD_WR),
  .CMD_WORD             (CMD_WORD),
  .MEM_ACCESS           (MEM_ACCESS),
  .PIX_COL              (PIX_COL),
  .HORIZONTAL_FLIP      (HORIZONTAL_FLIP),
  .VERTICAL_FLIP        (VERTICAL_FLIP),
  .DUMMY_LINE_COUNT     (DUMMY_LINE_COUNT),
  .DUMMY_LINES          (DUMMY_LINES),
  .SCAN_LINE_INDEX      (SCAN_LINE_INDEX),
  .LAST_SCAN_LINE       (LAST_SCAN_LINE),
  .COLUMN_POINTER_START (COLUMN_POINTER_START),
  .ROW_POINTER_START    (ROW_POINTER_START),
  .X_AUTO_STEP          (X_AUTO_STEP),
  .Y_AUTO_STEP          (Y_AUTO_STEP),
  .GRAY_DEPTH_SELECT    (GRAY_DEPTH_SELECT),
  .GRAY_DEPTH_VALID     (GRAY_DEPTH_VALID),
  .X_PTR                (X_PTR),
  .Y_PTR                (Y_PTR),
  .PIX_COL_MAPPED       (PIX_COL_MAPPED)
);
`default_nettype wire

// File: src/dsr_pkg.sv
// Constants for the display scan and memory pointer setup register bank
// Functional notes
// RULE1: horizontal flip mirrors pixels at write time
// RULE2: vertical flip shows image upside down
// RULE3: dummy count codes give 1,2,4,8 lines
// RULE4: scan index n selects line n+1, default 47h
// RULE5: host never writes scan codes 48h-7Fh
// RULE6: command 13h loads X pointer start
// RULE7: command 14h loads Y pointer start
// RULE8: X auto step advances X per access
// RULE9: Y auto step advances Y per access
// RULE10: gray depth field decoded to display modes
// RULE11: all these registers are write-only
// RULE12: word holds command high, data low byte
// RULE13: fixed-zero data bits are ignored
package dsr_pkg;
  // ==========================================
  // Command codes
  localparam logic [7:0] CMD_DIR   = 8'h11;
  localparam logic [7:0] CMD_SCAN  = 8'h12;
  localparam logic [7:0] CMD_XSTRT = 8'h13;
  localparam logic [7:0] CMD_YSTRT = 8'h14;
  localparam logic [7:0] CMD_GRAY  = 8'h15;
  // ==========================================
  // Field positions
  localparam int HFLIP_BIT = 0;
  localparam int VFLIP_BIT = 1;
  localparam int DUMMY_LSB = 4;
  localparam int XSTEP_BIT = 0;
  localparam int YSTEP_BIT = 1;
  localparam int GRAY_LSB  = 4;
  // ==========================================
  // Reset values and scan code limit
  localparam logic [1:0] DUMMY_RST = 2'h0;
  localparam logic [6:0] SCAN_RST  = 7'h47;
  localparam logic [6:0] SCAN_MAX  = 7'h47;
  localparam logic [7:0] XSTRT_RST = 8'h00;
  localparam logic [7:0] YSTRT_RST = 8'h00;
  localparam logic [3:0] GRAY_RST  = 4'h0;
  // ==========================================
  // Decoded display modes
  typedef enum logic [3:0] {
    DSR_G16   = 4'h0,
    DSR_G4P1  = 4'h2,
    DSR_G4P2  = 4'h3,
    DSR_G64M1 = 4'h4,
    DSR_G64M2 = 4'h5,
    DSR_MONO1 = 4'h8,
    DSR_MONO3 = 4'h9,
    DSR_MONO4 = 4'hB
  } dsr_gray_t;
endpackage

// File: src/dsr_ptr_step.sv
// Display memory pointer: start load and auto step
`timescale 1ns/10ps
`default_nettype none
module dsr_ptr_step #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] start,
  input  wire logic         step_en,
  input  wire logic         access,
  output logic [W-1:0]      ptr
);
  // ==========================================
  // State
  typedef struct packed {
    logic [W-1:0] ptr;
  } dsr_ptr_st_t;
  dsr_ptr_st_t s_r;
  dsr_ptr_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.ptr = start;
    end else if (access && step_en) begin
      s_nxt.ptr = s_r.ptr + {{(W-1){1'b0}}, 1'b1}; // [RULE8] [RULE9]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ptr = s_r.ptr;
endmodule
`default_nettype wire

// File: src/dsr_regs.sv
// Write-only scan and display memory setup registers
`timescale 1ns/10ps
`default_nettype none
module dsr_regs (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CMD_WR,
  input  wire logic [15:0] CMD_WORD,
  input  wire logic        MEM_ACCESS,
  input  wire logic [7:0]  PIX_COL,
  output logic             HORIZONTAL_FLIP,
  output logic             VERTICAL_FLIP,
  output logic [1:0]       DUMMY_LINE_COUNT,
  output logic [3:0]       DUMMY_LINES,
  output logic [6:0]       SCAN_LINE_INDEX,
  output logic [6:0]       LAST_SCAN_LINE,
  output logic [7:0]       COLUMN_POINTER_START,
  output logic [7:0]       ROW_POINTER_START,
  output logic             X_AUTO_STEP,
  output logic             Y_AUTO_STEP,
  output logic [3:0]       GRAY_DEPTH_SELECT,
  output logic             GRAY_DEPTH_VALID,
  output logic [7:0]       X_PTR,
  output logic [7:0]       Y_PTR,
  output logic [7:0]       PIX_COL_MAPPED
);
  // ==========================================
  // State
  typedef struct packed {
    logic       hflip;
    logic       vflip;
    logic [1:0] dummy;
    logic [3:0] dlines;
    logic [6:0] scan;
    logic [6:0] last;
    logic [7:0] xstart;
    logic [7:0] ystart;
    logic       xstep;
    logic       ystep;
    logic [3:0] gray;
    logic       gvalid;
    logic [7:0] colmap;
  } dsr_state_t;

  dsr_state_t s_r;
  dsr_state_t s_nxt;
  logic [7:0] cmd;
  logic [7:0] dat;
  logic [1:0] ptr_load;
  logic [1:0] ptr_step;
  logic [7:0] ptr_val [2];

  assign cmd         = CMD_WORD[15:8]; // [RULE12]
  assign dat         = CMD_WORD[7:0];
  // Index 0 is the X axis, index 1 the Y axis
  assign ptr_load[0] = CMD_WR && (cmd == dsr_pkg::CMD_XSTRT); // [RULE6]
  assign ptr_load[1] = CMD_WR && (cmd == dsr_pkg::CMD_YSTRT); // [RULE7]
  assign ptr_step[0] = s_r.xstep; // [RULE8]
  assign ptr_step[1] = s_r.ystep; // [RULE9]

  // ==========================================
  // Command decode
  always_comb begin
    s_nxt = s_r;
    if (CMD_WR) begin
      unique case (cmd)
        dsr_pkg::CMD_DIR: begin
          // Bits 7,6,3,2 dropped [RULE13]
          s_nxt.hflip = dat[dsr_pkg::HFLIP_BIT]; // [RULE1]
          s_nxt.vflip = dat[dsr_pkg::VFLIP_BIT]; // [RULE2]
          s_nxt.dummy = dat[dsr_pkg::DUMMY_LSB +: 2]; // [RULE3]
        end
        dsr_pkg::CMD_SCAN: begin
          s_nxt.scan = dat[6:0]; // [RULE4] [RULE13]
        end
        dsr_pkg::CMD_XSTRT: begin
          s_nxt.xstart = dat; // [RULE6]
        end
        dsr_pkg::CMD_YSTRT: begin
          s_nxt.ystart = dat; // [RULE7]
        end
        dsr_pkg::CMD_GRAY: begin
          s_nxt.xstep = dat[dsr_pkg::XSTEP_BIT]; // [RULE8]
          s_nxt.ystep = dat[dsr_pkg::YSTEP_BIT]; // [RULE9]
          s_nxt.gray  = dat[dsr_pkg::GRAY_LSB +: 4]; // [RULE10]
        end
        default: begin
          s_nxt = s_r;
        end
      endcase
    end
    // Dummy lines ahead of each scan line [RULE3]
    unique case (s_nxt.dummy)
      2'h0: begin
        s_nxt.dlines = 4'h1;
      end
      2'h1: begin
        s_nxt.dlines = 4'h2;
      end
      2'h2: begin
        s_nxt.dlines = 4'h4;
      end
      2'h3: begin
        s_nxt.dlines = 4'h8;
      end
    endcase
    // Line number is code plus one; reserved codes left as written [RULE4] [RULE5]
    s_nxt.last = s_nxt.scan + 7'h01;
    // Legal gray depth modes [RULE10]
    unique case (s_nxt.gray)
      dsr_pkg::DSR_G16, dsr_pkg::DSR_G4P1, dsr_pkg::DSR_G4P2,
      dsr_pkg::DSR_G64M1, dsr_pkg::DSR_G64M2, dsr_pkg::DSR_MONO1,
      dsr_pkg::DSR_MONO3, dsr_pkg::DSR_MONO4: begin
        s_nxt.gvalid = 1'h1;
      end
      default: begin
        s_nxt.gvalid = 1'h0;
      end
    endcase
    // Mirror column at write time [RULE1]
    s_nxt.colmap = s_nxt.hflip ? ~PIX_COL : PIX_COL;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_r.hflip  <= 1'b0;
      s_r.vflip  <= 1'b0;
      s_r.dummy  <= dsr_pkg::DUMMY_RST;
      s_r.dlines <= 4'h1 << dsr_pkg::DUMMY_RST;
      s_r.scan   <= dsr_pkg::SCAN_RST;
      s_r.last   <= dsr_pkg::SCAN_RST + 7'h01;
      s_r.xstart <= dsr_pkg::XSTRT_RST;
      s_r.ystart <= dsr_pkg::YSTRT_RST;
      s_r.xstep  <= 1'b0;
      s_r.ystep  <= 1'b0;
      s_r.gray   <= dsr_pkg::GRAY_RST;
      s_r.gvalid <= 1'h1;
      s_r.colmap <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Pointers, one per axis
  for (genvar a = 0; a < 2; a++) begin : g_axis
    dsr_ptr_step #(.W(8)) u_ptr (
      .clk     (CLK),
      .rst     (SYS_RST),
      .load    (ptr_load[a]),
      .start   (dat),
      .step_en (ptr_step[a]),
      .access  (MEM_ACCESS),
      .ptr     (ptr_val[a])
    );
  end

  // ==========================================
  // Outputs; no read path exists [RULE11]
  assign HORIZONTAL_FLIP      = s_r.hflip;
  assign VERTICAL_FLIP        = s_r.vflip; // [RULE2]
  assign DUMMY_LINE_COUNT     = s_r.dummy;
  assign DUMMY_LINES          = s_r.dlines; // [RULE3]
  assign SCAN_LINE_INDEX      = s_r.scan;
  assign LAST_SCAN_LINE       = s_r.last; // [RULE4]
  assign COLUMN_POINTER_START = s_r.xstart;
  assign ROW_POINTER_START    = s_r.ystart;
  assign X_AUTO_STEP          = s_r.xstep;
  assign Y_AUTO_STEP          = s_r.ystep;
  assign GRAY_DEPTH_SELECT    = s_r.gray;
  assign PIX_COL_MAPPED       = s_r.colmap;
  assign GRAY_DEPTH_VALID     = s_r.gvalid; // [RULE10]
  assign X_PTR                = ptr_val[0];
  assign Y_PTR                = ptr_val[1];
endmodule
`default_nettype wire
